// ### inc/hib_consts.vh
// Purpose: Register map, field positions and timing counts of the hibernation controller
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Definitions only
`ifndef HIB_CONSTS_VH
`define HIB_CONSTS_VH

// Register byte offsets
`define OFS_COUNTER      12'h000
`define OFS_CMP0         12'h004
`define OFS_CMP1         12'h008
`define OFS_LOAD         12'h00C
`define OFS_CTRL         12'h010
`define OFS_IRQ_MASK     12'h014
`define OFS_IRQ_RAW      12'h018
`define OFS_IRQ_MASKED   12'h01C
`define OFS_IRQ_CLEAR    12'h020

// Interrupt bit positions
`define IRQ_WR_DONE      0
`define IRQ_PIN_WAKE     1
`define IRQ_BATTERY_LOW  2
`define IRQ_CMP0         3
`define IRQ_CMP1         4
`define IRQ_WIDTH        5

// Control field positions
`define CTRL_COUNT_EN    0
`define CTRL_HIB_REQ     1
`define CTRL_WAKE_PIN    3
`define CTRL_WAKE_CMP    4
`define CTRL_WAKE_BAT    5
`define CTRL_BAT_EN      6
`define CTRL_BAT_ABORT   7
`define CTRL_BAT_SEL_LO  8
`define CTRL_BAT_SEL_HI  9
`define CTRL_ACTIVE      31

// Reset values
`define CTRL_RESET       10'h000
`define MASK_RESET       5'h00

// Timing: write settle time into the slow domain, and the seconds tick
`define WR_SETTLE_NS     92
`define CLK_PERIOD_NS    4
`define WR_SETTLE_CYC    ((`WR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLK_HZ           250000000

`endif

// ### design/hib_tick_div.v
// Purpose: Divider producing a one-cycle enable once per period
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Clears count to zero while run is low
`timescale 1ns/1ns
`default_nettype none

module hib_tick_div #(
    parameter integer DIVIDE = 250000000
) (
    // Clock and reset
    input  wire clk,
    input  wire rst,
    // Control
    input  wire run,
    // Tick output
    output reg  tick
);

    reg [31:0] count_reg;

    // Count up to DIVIDE-1 then emit a pulse
    always @(posedge clk)
    begin
        if (rst)
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b0;
        end
        else if (!run)
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b0;
        end
        else if (count_reg == DIVIDE[31:0] - 32'h0000_0001)
        begin
            count_reg <= 32'h0000_0000;
            tick      <= 1'b1;
        end
        else
        begin
            count_reg <= count_reg + 32'h0000_0001;
            tick      <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### design/hib_ctrl.v
// Purpose: Always-powered hibernation controller with seconds counter and compares
// Assumes: APB slave, 32-bit data; rst is the hibernation domain reset, not the CPU POR
// Notes:   Battery compare level and wake pin arrive from pins and are synchronised
//
// Overview of operation
// [R01] Five interrupt sources, each with its own enable bit, any combination.
// [R02] Raw and masked status readable, same bit positions as enable mask.
// [R03] Single interrupt output high while any masked status bit is set.
// [R04] Writing ones to the clear mask clears those pending flags.
// [R05] Control register shows block already active, surviving processor reset.
// [R06] Low battery with detection enabled sets the low-battery raw flag.
// [R07] Abort mode cancels a pending hibernation request on low battery.
// [R08] Threshold select field, four levels, forwarded to the battery comparator.
// [R09] Battery mode and threshold read back as written.
// [R10] Hibernation request drops regulator enable unless an abort condition exists.
// [R11] While hibernating, any enabled wake condition raises regulator enable again.
// [R12] State survives the processor power-on reset; only rst clears it.
// [R13] Software sets wake enables first and tolerates running on after request.
// [R14] Separate wake enables for pin, compare match and low battery.
// [R15] Counter enable gates counting, compare matches and their effects.
// [R16] Seconds counter advances once per second, readable as whole seconds.
// [R17] Compare 0 register is writable and reads back unchanged.
// [R18] Counter equal compare 0 sets match flag, interrupt and wake if enabled.
// [R19] Write-complete flag set once a slow-domain write has settled.
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "hib_consts.vh"

module hib_ctrl #(
    parameter integer TICK_DIVIDE = `CLK_HZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Interrupt
    output reg         irq,
    // Regulator, wake pin and battery monitor
    input  wire        wake_pin,
    input  wire        battery_low_in,
    output reg         regulator_en,
    output reg  [1:0]  battery_threshold_sel,
    output reg         battery_compare_en
);

    localparam [1:0] ST_RUN   = 2'b00;
    localparam [1:0] ST_ARMED = 2'b01;
    localparam [1:0] ST_HIB   = 2'b10;

    // Settle count cut to the width of its counter on purpose
    localparam integer SETTLE_CYC = `WR_SETTLE_CYC;
    localparam [7:0]   SETTLE     = SETTLE_CYC[7:0];

    reg [31:0] counter_reg;
    reg [31:0] cmp0_reg;
    reg [31:0] cmp1_reg;
    reg [9:0]  ctrl_reg;
    reg        active_reg;
    reg [4:0]  mask_reg;
    reg [4:0]  raw_reg;
    reg [4:0]  raw_next;
    reg [1:0]  state_reg;
    reg [7:0]  settle_reg;
    reg        wake_meta_reg;
    reg        wake_sync_reg;
    reg        bat_meta_reg;
    reg        bat_sync_reg;
    reg [2:0]  bat_en_dly_reg;
    reg        cmp0_hit_reg;
    reg        cmp1_hit_reg;
    reg [31:0] rdata_next;
    reg        addr_ok;

    wire       tick;
    wire       wr_en;
    wire       rd_en;
    wire       count_en;
    wire       bat_low;
    wire       cmp0_now;
    wire       cmp1_now;
    wire [4:0] events;
    wire       wake_any;

    // Decode for a known register offset
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `OFS_COUNTER) || (a == `OFS_CMP0) || (a == `OFS_CMP1)
                     || (a == `OFS_LOAD) || (a == `OFS_CTRL) || (a == `OFS_IRQ_MASK)
                     || (a == `OFS_IRQ_RAW) || (a == `OFS_IRQ_MASKED)
                     || (a == `OFS_IRQ_CLEAR);
        end
    endfunction

    // Access phase strobes, one-cycle answer
    assign wr_en    = psel && penable && pwrite && !pready;
    assign rd_en    = psel && penable && !pwrite && !pready;
    assign count_en = ctrl_reg[`CTRL_COUNT_EN];
    // Comparator output ignored until its enable has passed the synchroniser
    assign bat_low  = ctrl_reg[`CTRL_BAT_EN] && bat_en_dly_reg[2] && bat_sync_reg;

    // Compare matches exist only while counting is enabled
    assign cmp0_now = count_en && (counter_reg == cmp0_reg);   // see [R15]
    assign cmp1_now = count_en && (counter_reg == cmp1_reg);

    // Event terms; pin and battery events are levels, compare events fire on entering equality
    assign events[`IRQ_WR_DONE]     = (settle_reg == 8'h01);   // see [R19]
    assign events[`IRQ_PIN_WAKE]    = wake_sync_reg;
    assign events[`IRQ_BATTERY_LOW] = bat_low;                 // see [R06]
    assign events[`IRQ_CMP0]        = cmp0_now && !cmp0_hit_reg; // see [R18]
    assign events[`IRQ_CMP1]        = cmp1_now && !cmp1_hit_reg;

    // Enabled wake sources
    assign wake_any = (ctrl_reg[`CTRL_WAKE_PIN] && wake_sync_reg)        // see [R14]
                   || (ctrl_reg[`CTRL_WAKE_CMP] && (cmp0_now || cmp1_now))
                   || (ctrl_reg[`CTRL_WAKE_BAT] && bat_low);

    // Seconds tick only while counter enabled
    hib_tick_div #(
        .DIVIDE (TICK_DIVIDE)
    ) u_tick (
        .clk    (clk),
        .rst    (rst),
        .run    (count_en),
        .tick   (tick)
    );

    // Two-stage synchronisers for pin inputs
    always @(posedge clk)
    begin
        if (rst)
        begin
            wake_meta_reg <= 1'b0;
            wake_sync_reg <= 1'b0;
            bat_meta_reg  <= 1'b0;
            bat_sync_reg  <= 1'b0;
        end
        else
        begin
            wake_meta_reg <= wake_pin;
            wake_sync_reg <= wake_meta_reg;
            bat_meta_reg  <= battery_low_in;
            bat_sync_reg  <= bat_meta_reg;
        end
    end

    // Enable delay matching the comparator register and both sync stages
    always @(posedge clk)
    begin
        if (rst)
            bat_en_dly_reg <= 3'h0;
        else
            bat_en_dly_reg <= {bat_en_dly_reg[1:0], battery_compare_en};
    end

    // Seconds counter, load and compare registers
    always @(posedge clk)
    begin
        if (rst)
        begin
            counter_reg  <= 32'h0000_0000;
            cmp0_reg     <= 32'hFFFF_FFFF;
            cmp1_reg     <= 32'hFFFF_FFFF;
            cmp0_hit_reg <= 1'b0;
            cmp1_hit_reg <= 1'b0;
        end
        else
        begin
            cmp0_hit_reg <= cmp0_now;
            cmp1_hit_reg <= cmp1_now;
            if (wr_en && paddr == `OFS_LOAD)
                counter_reg <= pwdata;
            else if (tick && count_en)
                counter_reg <= counter_reg + 32'h0000_0001;   // see [R16]
            if (wr_en && paddr == `OFS_CMP0)
                cmp0_reg <= pwdata;                           // see [R17]
            if (wr_en && paddr == `OFS_CMP1)
                cmp1_reg <= pwdata;
        end
    end

    // Control register; hibernation request bit is self-clearing by the state machine
    always @(posedge clk)
    begin
        if (rst)                                              // see [R12]
        begin
            ctrl_reg   <= `CTRL_RESET;
            active_reg <= 1'b0;
            mask_reg   <= `MASK_RESET;
        end
        else
        begin
            if (wr_en && paddr == `OFS_CTRL)
            begin
                ctrl_reg   <= pwdata[9:0];                    // see [R09]
                active_reg <= 1'b1;                           // see [R05]
            end
            else if (state_reg == ST_ARMED)
                ctrl_reg[`CTRL_HIB_REQ] <= 1'b0;
            if (wr_en && paddr == `OFS_IRQ_MASK)
                mask_reg <= pwdata[4:0];                      // see [R01]
        end
    end

    // Settle counter for writes crossing into the slow domain
    always @(posedge clk)
    begin
        if (rst)
            settle_reg <= 8'h00;
        else if (wr_en && (paddr == `OFS_LOAD || paddr == `OFS_CMP0 ||
                           paddr == `OFS_CMP1 || paddr == `OFS_CTRL))
            settle_reg <= SETTLE;
        else if (settle_reg != 8'h00)
            settle_reg <= settle_reg - 8'h01;
    end

    // Sticky raw flags: set wins over clear
    always @*
    begin
        raw_next = raw_reg;
        if (wr_en && paddr == `OFS_IRQ_CLEAR)
            raw_next = raw_next & ~pwdata[4:0];               // see [R04]
        raw_next = raw_next | events;
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            raw_reg <= 5'h00;
            irq     <= 1'b0;
        end
        else
        begin
            raw_reg <= raw_next;
            irq     <= |(raw_next & mask_reg);                // see [R03]
        end
    end

    // Hibernation sequencing of the regulator enable
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_reg    <= ST_RUN;
            regulator_en <= 1'b1;
        end
        else
        begin
            case (state_reg)
                ST_RUN:
                begin
                    regulator_en <= 1'b1;
                    if (ctrl_reg[`CTRL_HIB_REQ])
                        state_reg <= ST_ARMED;
                end
                ST_ARMED:
                begin
                    if (ctrl_reg[`CTRL_BAT_ABORT] && bat_low)   // see [R07]
                        state_reg <= ST_RUN;
                    else
                    begin
                        regulator_en <= 1'b0;                   // see [R10]
                        state_reg    <= ST_HIB;
                    end
                end
                ST_HIB:
                begin
                    if (wake_any)
                    begin
                        regulator_en <= 1'b1;                   // see [R11]
                        state_reg    <= ST_RUN;
                    end
                end
                default:
                begin
                    regulator_en <= 1'b1;
                    state_reg    <= ST_RUN;
                end
            endcase
        end
    end

    // Battery comparator controls
    always @(posedge clk)
    begin
        if (rst)
        begin
            battery_threshold_sel <= 2'b00;
            battery_compare_en    <= 1'b0;
        end
        else
        begin
            battery_threshold_sel <= ctrl_reg[`CTRL_BAT_SEL_HI:`CTRL_BAT_SEL_LO]; // see [R08]
            battery_compare_en    <= ctrl_reg[`CTRL_BAT_EN];
        end
    end

    // Read multiplexer
    always @*
    begin
        addr_ok    = is_mapped(paddr);
        rdata_next = 32'h0000_0000;
        case (paddr)
            `OFS_COUNTER:    rdata_next = counter_reg;
            `OFS_CMP0:       rdata_next = cmp0_reg;
            `OFS_CMP1:       rdata_next = cmp1_reg;
            `OFS_LOAD:       rdata_next = counter_reg;
            `OFS_CTRL:
            begin
                rdata_next[9:0]          = ctrl_reg;
                rdata_next[`CTRL_ACTIVE] = active_reg;
            end
            `OFS_IRQ_MASK:   rdata_next[4:0] = mask_reg;
            `OFS_IRQ_RAW:    rdata_next[4:0] = raw_reg;            // see [R02]
            `OFS_IRQ_MASKED: rdata_next[4:0] = raw_reg & mask_reg; // see [R02]
            default:         rdata_next = 32'h0000_0000;
        endcase
    end

    // APB answer one cycle into the access phase
    always @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= wr_en || rd_en;
            pslverr <= (wr_en || rd_en) && !addr_ok;
            prdata  <= rd_en ? rdata_next : 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// ### verification/hib_ctrl_asserts.sv
// Purpose: Port-level checks of the hibernation controller
// Assumes: Bound into hib_ctrl, one clock, synchronous active-high reset
// Notes:   Tracks the wake-pin enable from CTRL writes seen on the bus
`timescale 1ns/1ns
`default_nettype none
`include "hib_consts.vh"

module hib_ctrl_asserts #(
    parameter integer TICK_DIVIDE = 10
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupt and power pins
    input wire logic        irq,
    input wire logic        wake_pin,
    input wire logic        battery_low_in,
    input wire logic        regulator_en,
    input wire logic [1:0]  battery_threshold_sel,
    input wire logic        battery_compare_en
);
    // Completed CTRL writes and the fields they carry, and completed all-zero IRQ mask writes
    logic       wake_pin_on;
    wire        ctrl_wr = pready && psel && penable && pwrite && (paddr == `OFS_CTRL);
    wire        hib_wr  = ctrl_wr && pwdata[`CTRL_HIB_REQ];
    wire [1:0]  wsel    = pwdata[9:8];
    wire        wcmp    = pwdata[`CTRL_BAT_EN];
    wire        mask0   = pready && pwrite && (paddr == `OFS_IRQ_MASK) && (pwdata[4:0] == 5'h00);

    // Wake-pin enable as last written
    always @(posedge clk)
        if (rst)
            wake_pin_on <= 1'b0;
        else if (ctrl_wr)
            wake_pin_on <= pwdata[`CTRL_WAKE_PIN];

    sequence access_take;
        psel && penable && !pready;
    endsequence
    sequence one_answer;
        pready ##1 !pready;
    endsequence

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_ready_wait: assert property (access_take |=> one_answer)
        else $error("ready not a single pulse after access");
    chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without a request");
    chk_err_map: assert property ((pready && paddr[1:0] == 2'b00)
        |-> (pslverr == (paddr > `OFS_IRQ_CLEAR))) else $error("slave error wrong");
    chk_rdata_idle: assert property ((!pready || pwrite) |-> prdata == 32'h00000000)
        else $error("read data outside a read answer");
    chk_sel_copy: assert property (ctrl_wr |=> battery_threshold_sel == $past(wsel)
        && battery_compare_en == $past(wcmp)) else $error("battery fields not forwarded");
    chk_irq_mask0: assert property (mask0 |=> !irq [*2])
        else $error("irq high with all sources masked");
    chk_hib_drop: assert property ($fell(regulator_en)
        |-> $past(hib_wr) || $past(hib_wr, 2) || $past(hib_wr, 3))
        else $error("regulator dropped without request");
    chk_pin_wake: assert property ((!regulator_en && wake_pin && wake_pin_on)
        |-> ##[1:6] regulator_en) else $error("pin wake ignored");
endmodule

bind hib_ctrl hib_ctrl_asserts #(.TICK_DIVIDE(TICK_DIVIDE)) chk_u (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .wake_pin(wake_pin), .battery_low_in(battery_low_in),
    .regulator_en(regulator_en), .battery_threshold_sel(battery_threshold_sel),
    .battery_compare_en(battery_compare_en)
);
`default_nettype wire

// ### verification/hib_power_model.sv
// Purpose: Regulator, wake switch and battery comparator beside the controller
// Assumes: Bench sets wake_cmd and bat_volt on rising edges
// Notes:   Comparator output toggles while disabled, so it must be gated
`timescale 1ns/1ns
`default_nettype none

module hib_power_model (
    // Clock and bench controls
    input  wire logic       clk,
    input  wire logic       wake_cmd,
    input  wire logic [2:0] bat_volt,
    // Controller side
    input  wire logic       regulator_en,
    input  wire logic [1:0] battery_threshold_sel,
    input  wire logic       battery_compare_en,
    output wire logic       wake_pin,
    output logic            battery_low_in,
    output wire logic       cpu_powered
);
    // Switch and regulator follow directly
    assign wake_pin    = wake_cmd;
    assign cpu_powered = regulator_en;

    initial battery_low_in = 1'b0;

    // Low when the level is at or below the selected trip point
    always @(posedge clk)
        if (battery_compare_en)
            battery_low_in <= (bat_volt <= {1'b0, battery_threshold_sel});
        else
            battery_low_in <= ~battery_low_in;
endmodule
`default_nettype wire

// ### verification/hib_ctrl_bench.sv
// Purpose: Self-checking bench of the hibernation controller
// Assumes: Short seconds divider; APB answers are noted in a queue
// Notes:   Read answers are compared by a monitor on the falling edge
`timescale 1ns/1ns
`default_nettype none
`include "hib_consts.vh"

module hib_ctrl_bench;
    localparam integer TICK = 10;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic        wake_cmd = 1'b0;
    logic [2:0]  bat_volt = 3'h7;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, wake_pin, battery_low_in, regulator_en;
    wire         battery_compare_en;
    wire  [1:0]  battery_threshold_sel;
    logic [32:0] exp_q[$];
    integer      err_total = 0;
    integer      samples_checked = 0;
    integer      seed = 15062;
    integer      i;
    logic [31:0] v;

    always #2 clk = ~clk;

    hib_ctrl #(.TICK_DIVIDE(TICK)) dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .wake_pin(wake_pin), .battery_low_in(battery_low_in), .regulator_en(regulator_en),
        .battery_threshold_sel(battery_threshold_sel), .battery_compare_en(battery_compare_en));
    hib_power_model part_u (.clk(clk), .wake_cmd(wake_cmd), .bat_volt(bat_volt),
        .regulator_en(regulator_en), .battery_threshold_sel(battery_threshold_sel),
        .battery_compare_en(battery_compare_en), .wake_pin(wake_pin),
        .battery_low_in(battery_low_in), .cpu_powered());

    task check(input logic [32:0] seen, input logic [32:0] want);
        samples_checked = samples_checked + 1;
        if (seen !== want)
        begin
            err_total = err_total + 1;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    task results;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One APB transfer; the expected answer is noted first
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        integer n;
        n = 0;
        exp_q.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 100)
        begin
            n = n + 1;
            @(posedge clk);
        end
        if (n >= 100)
            err_total = err_total + 1; // Answer never came
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 33'h000000000);
    endtask

    task rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000, {1'b0, e});
    endtask

    task pin_is(input logic want);
        @(negedge clk);
        check({32'h00000000, regulator_en}, {32'h00000000, want});
    endtask

    // Answer monitor
    always @(negedge clk)
        if (pready === 1'b1)
            check({pslverr, prdata}, exp_q.pop_front());

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total = err_total + 1;
        results;
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // Reset values and unmapped places
        rd(`OFS_CTRL, 32'h00000000);
        rd(`OFS_CMP0, 32'hFFFFFFFF);
        rd(`OFS_IRQ_RAW, 32'h00000000);
        xfer(1'b1, 12'h100, 32'h00000001, {1'b1, 32'h00000000});
        xfer(1'b0, 12'h104, 32'h00000000, {1'b1, 32'h00000000});
        v = $random(seed);
        wr(`OFS_CMP0, v);
        rd(`OFS_CMP0, v);
        // Every threshold code, both battery modes
        for (i = 0; i < 4; i = i + 1)
        begin
            v = {22'h000000, i[1:0], i[0], 7'h40};
            wr(`OFS_CTRL, v);
            @(negedge clk);
            check({31'h00000000, battery_threshold_sel}, {31'h00000000, i[1:0]});
            rd(`OFS_CTRL, v | 32'h80000000);
        end
        // Write-done flag, mask, masked view, clear
        repeat (30) @(posedge clk);
        rd(`OFS_IRQ_RAW, 32'h00000001);
        wr(`OFS_IRQ_MASK, 32'h00000001);
        repeat (3) @(negedge clk);
        check({32'h00000000, irq}, 33'h000000001);
        rd(`OFS_IRQ_MASKED, 32'h00000001);
        wr(`OFS_IRQ_CLEAR, 32'h00000001);
        repeat (3) @(negedge clk);
        check({32'h00000000, irq}, 33'h000000000);
        rd(`OFS_IRQ_RAW, 32'h00000000);
        wr(`OFS_IRQ_MASK, 32'h0000001F);
        // Counter held while disabled, then compare wakes from hibernation
        v = $random(seed);
        v[31] = 1'b0; // Stay clear of the compare 1 reset value
        wr(`OFS_LOAD, v);
        wr(`OFS_CMP0, v + 32'h00000003);
        repeat (40) @(posedge clk);
        rd(`OFS_COUNTER, v);
        wr(`OFS_IRQ_CLEAR, 32'h0000001F);
        wr(`OFS_CTRL, 32'h00000013);
        repeat (3) @(posedge clk);
        pin_is(1'b0);
        repeat (60) @(posedge clk);
        pin_is(1'b1);
        rd(`OFS_IRQ_RAW, 32'h00000009);
        // Low battery in abort mode keeps power on; detection armed first
        wr(`OFS_IRQ_CLEAR, 32'h0000001F);
        bat_volt <= 3'h0;
        wr(`OFS_CTRL, 32'h000000C0);
        repeat (8) @(posedge clk);
        wr(`OFS_CTRL, 32'h000000C2);
        repeat (30) @(posedge clk);
        pin_is(1'b1);
        rd(`OFS_IRQ_RAW, 32'h00000005);
        bat_volt <= 3'h7;
        // Pin ignored until its wake enable is set
        wr(`OFS_CTRL, 32'h00000002);
        wake_cmd <= 1'b1;
        repeat (20) @(posedge clk);
        pin_is(1'b0);
        wr(`OFS_CTRL, 32'h00000008);
        repeat (8) @(posedge clk);
        pin_is(1'b1);
        @(posedge clk);
        wake_cmd <= 1'b0;
        rd(`OFS_CTRL, 32'h80000008);
        // Pin rising while asleep with its wake enabled
        wr(`OFS_CTRL, 32'h0000000A);
        repeat (10) @(posedge clk);
        pin_is(1'b0);
        @(posedge clk);
        wake_cmd <= 1'b1;
        repeat (8) @(posedge clk);
        pin_is(1'b1);
        @(posedge clk);
        wake_cmd <= 1'b0;
        // Low battery wakes through its own wake enable
        wr(`OFS_CTRL, 32'h00000062);
        repeat (10) @(posedge clk);
        pin_is(1'b0);
        @(posedge clk);
        bat_volt <= 3'h0;
        repeat (10) @(posedge clk);
        pin_is(1'b1);
        @(posedge clk);
        bat_volt <= 3'h7;
        wr(`OFS_IRQ_MASK, 32'h00000000);
        repeat (3) @(negedge clk);
        check({32'h00000000, irq}, 33'h000000000);
        results;
    end
endmodule
`default_nettype wire
